// File: design/pbd_alt_override.sv
// alternate-function override logic for port b and port d pins
// assumes port registers, peripherals and pads all run on clock
// Summary of operation
// - timer1 compare-A drives port b bit 3 when enabled; needs direction output.
// - timer0 compare-A drives port b bit 2 when enabled; needs direction output.
// - each port b pin forces input on when masked and pin-change enabled.
// - serial data paths split into master and slave input and output halves.
// - three-wire drives bit 6 with data out; two-wire takes bit 5 if direction.
// - port d bit 6 feeds capture trigger, input forced on when enabled.
// - timer0 compare-B drives port d bit 5 when enabled and output.
// - port d bit 5 clocks timer1 when its select bits 2 and 1 set.
// - port d bit 4 clocks timer0 when its select bits 2 and 1 set.
// - port d bits 6,5,4 force input on while their function is enabled.
// - port d bits 3,2 are external irq inputs, input forced when enabled.
// - port d bit 2 carries usart clock only in synchronous mode.
// - port d bit 2 outputs the system clock when clock output selected; needs direction output.
// - transmitter enabled: bit 1 pull-up off, output, tx data, input off.
// - receiver enabled: bit 0 input to receiver, pull-up from port and disable.
// - pull-up follows override when enabled, else input, port one, no disable.
// - value override replaces port data when driving; toggle inverts port data.
`include "pbd_params.svh"
module pbd_alt_override #(
   parameter int BW = `PBD_PORTB_W,
   parameter int DW = `PBD_PORTD_W
) (
   input  wire logic          clock,
   input  wire logic          resetn,
   input  wire logic          globalPullupDisable,
   input  wire logic          sleepMode,
   input  wire logic [BW-1:0] portB,
   input  wire logic [BW-1:0] directionB,
   input  wire logic [BW-1:0] padInB,
   input  wire logic [DW-1:0] portD,
   input  wire logic [DW-1:0] directionD,
   input  wire logic [DW-1:0] padInD,
   input  wire logic [BW-1:0] pinChangeMask,
   input  wire logic          pinChangeIrqEn,
   input  wire logic          serialUnit2wireMode,
   input  wire logic          serialUnit3wireMode,
   input  wire logic          serialUnitClockStretch,
   input  wire logic          serialUnitStartIrqEn,
   input  wire logic          serialUnitClockToggle,
   input  wire logic          serialDataOut,
   input  wire logic          timer1CompareAEn,
   input  wire logic          timer1CompareAOut,
   input  wire logic          timer1CompareBEn,
   input  wire logic          timer1CompareBOut,
   input  wire logic          timer0CompareAEn,
   input  wire logic          timer0CompareAOut,
   input  wire logic          timer0CompareBEn,
   input  wire logic          timer0CompareBOut,
   input  wire logic          captureEn,
   input  wire logic [1:0]    timer1ClockSelect21,
   input  wire logic [1:0]    timer0ClockSelect21,
   input  wire logic          extIrqOneEn,
   input  wire logic          extIrqZeroEn,
   input  wire logic          usartSyncMode,
   input  wire logic          usartSyncClockOutEn,
   input  wire logic          usartSyncClockOut,
   input  wire logic          sysclkOutputSel,
   input  wire logic          sysclkLevel,
   input  wire logic          txEnable,
   input  wire logic          txData,
   input  wire logic          rxEnable,
   output logic [BW-1:0]      pullupB,
   output logic [BW-1:0]      driveEnB,
   output logic [BW-1:0]      driveValB,
   output logic [BW-1:0]      inputEnB,
   output logic [DW-1:0]      pullupD,
   output logic [DW-1:0]      driveEnD,
   output logic [DW-1:0]      driveValD,
   output logic [DW-1:0]      inputEnD,
   output logic [BW-1:0]      pinChangeSource,
   output logic               serialUnitClockPin,
   output logic               serialDataIn,
   output logic               captureTriggerIn,
   output logic               timer1ExtCountClock,
   output logic               timer0ExtCountClock,
   output logic               extIrqOneInput,
   output logic               extIrqZeroInput,
   output logic               usartSyncClockIn,
   output logic               rxDataIn
);
   import pbd_pkg::*;

   // override terms, one bit per pin
   logic [BW-1:0] bPuoe, bPuov, bDdoe, bDdov, bPvoe, bPvov, bPtoe, bDieoe, bDieov;
   logic [DW-1:0] dPuoe, dPuov, dDdoe, dDdov, dPvoe, dPvov, dPtoe, dDieoe, dDieov;
   logic [BW-1:0] digB;
   logic [DW-1:0] digD;
   logic          t1ClkEn, t0ClkEn, xckInEn;
   pbd_route_s    route_reg;
   pbd_route_s    route_next;

   assign t1ClkEn = &timer1ClockSelect21;
   assign t0ClkEn = &timer0ClockSelect21;
   assign xckInEn = usartSyncMode & ~usartSyncClockOutEn;

   // *************************
   // port b override terms
   // *************************
   always_comb begin
      {bPuoe, bPuov, bDdoe, bDdov, bPvoe, bPvov, bPtoe} = '0;
      // pin-change keeps the input alive even in sleep
      bDieoe = pinChangeMask & {BW{pinChangeIrqEn}};
      bDieov = '1;
      bDieoe[`PBD_PB_SCLK] = bDieoe[`PBD_PB_SCLK] | serialUnitStartIrqEn;
      bDieoe[`PBD_PB_SDA]  = bDieoe[`PBD_PB_SDA] | serialUnitStartIrqEn;
      // two-wire pins only ever pull low: value forced zero, driver gated
      bDdoe[`PBD_PB_SCLK] = serialUnit2wireMode;
      bDdov[`PBD_PB_SCLK] = (serialUnitClockStretch | ~portB[`PBD_PB_SCLK])
                          & directionB[`PBD_PB_SCLK];
      bPvoe[`PBD_PB_SCLK] = serialUnit2wireMode & directionB[`PBD_PB_SCLK];
      bPtoe[`PBD_PB_SCLK] = serialUnitClockToggle;
      bDdoe[`PBD_PB_SDA] = serialUnit2wireMode;
      bDdov[`PBD_PB_SDA] = ~portB[`PBD_PB_SDA] & directionB[`PBD_PB_SDA];
      bPvoe[`PBD_PB_SDA] = serialUnit2wireMode & directionB[`PBD_PB_SDA];
      // data out is the master-out / slave-out half of the serial pair
      bPvoe[`PBD_PB_SDO] = serialUnit3wireMode;
      bPvov[`PBD_PB_SDO] = serialDataOut;
      bPvoe[`PBD_PB_T1CB] = timer1CompareBEn;
      bPvov[`PBD_PB_T1CB] = timer1CompareBOut;
      bPvoe[`PBD_PB_T1CA] = timer1CompareAEn;
      bPvov[`PBD_PB_T1CA] = timer1CompareAOut;
      bPvoe[`PBD_PB_T0CA] = timer0CompareAEn;
      bPvov[`PBD_PB_T0CA] = timer0CompareAOut;
      // bits 1 and 0 have no override beyond the pin-change input enable; analog use is left to software
   end

   // *************************
   // port d override terms
   // *************************
   always_comb begin
      {dPuoe, dPuov, dDdoe, dDdov, dPvoe, dPvov, dPtoe, dDieoe} = '0;
      dDieov = '1;
      dDieoe[`PBD_PD_CAPT] = captureEn;
      dDieoe[`PBD_PD_T1CK] = t1ClkEn;
      dDieoe[`PBD_PD_T0CK] = t0ClkEn;
      dDieoe[`PBD_PD_IRQ1] = extIrqOneEn;
      dDieoe[`PBD_PD_IRQ0] = extIrqZeroEn | xckInEn;
      dPvoe[`PBD_PD_T1CK] = timer0CompareBEn;
      dPvov[`PBD_PD_T1CK] = timer0CompareBOut;
      // clock output wins over the usart clock: a stray tap must not glitch it
      if (sysclkOutputSel) begin
         dPvoe[`PBD_PD_IRQ0] = 1'b1;
         dPvov[`PBD_PD_IRQ0] = sysclkLevel;
      end else begin
         dPvoe[`PBD_PD_IRQ0] = usartSyncMode & usartSyncClockOutEn;
         dPvov[`PBD_PD_IRQ0] = usartSyncClockOut;
      end
      dPuoe[`PBD_PD_TXD] = txEnable;
      dDdoe[`PBD_PD_TXD] = txEnable;
      dDdov[`PBD_PD_TXD] = 1'b1;
      dPvoe[`PBD_PD_TXD] = txEnable;
      dPvov[`PBD_PD_TXD] = txData;
      dDieoe[`PBD_PD_TXD] = txEnable;
      dDieov[`PBD_PD_TXD] = 1'b0;
      dPuoe[`PBD_PD_RXD] = rxEnable;
      dPuov[`PBD_PD_RXD] = portD[`PBD_PD_RXD] & ~globalPullupDisable;
      dDdoe[`PBD_PD_RXD] = rxEnable;
   end

   // *************************
   // pin cells
   // *************************
   genvar gi;
   generate
      for (gi = 0; gi < BW; gi++) begin : g_portb
         pbd_pin_cell u_cell (
            .clock(clock), .resetn(resetn), .direction(directionB[gi]),
            .portBit(portB[gi]), .globalPullupDisable(globalPullupDisable),
            .sleepMode(sleepMode), .padIn(padInB[gi]),
            .pullupOverrideEn(bPuoe[gi]), .pullupOverrideVal(bPuov[gi]),
            .directionOverrideEn(bDdoe[gi]), .directionOverrideVal(bDdov[gi]),
            .valueOverrideEn(bPvoe[gi]), .valueOverrideVal(bPvov[gi]),
            .toggleOverrideEn(bPtoe[gi]), .inputEnableOverrideEn(bDieoe[gi]),
            .inputEnableOverrideVal(bDieov[gi]), .pullupEn(pullupB[gi]),
            .driveEn(driveEnB[gi]), .driveVal(driveValB[gi]),
            .inputEn(inputEnB[gi]), .digitalIn(digB[gi]));
      end
      for (gi = 0; gi < DW; gi++) begin : g_portd
         pbd_pin_cell u_cell (
            .clock(clock), .resetn(resetn), .direction(directionD[gi]),
            .portBit(portD[gi]), .globalPullupDisable(globalPullupDisable),
            .sleepMode(sleepMode), .padIn(padInD[gi]),
            .pullupOverrideEn(dPuoe[gi]), .pullupOverrideVal(dPuov[gi]),
            .directionOverrideEn(dDdoe[gi]), .directionOverrideVal(dDdov[gi]),
            .valueOverrideEn(dPvoe[gi]), .valueOverrideVal(dPvov[gi]),
            .toggleOverrideEn(dPtoe[gi]), .inputEnableOverrideEn(dDieoe[gi]),
            .inputEnableOverrideVal(dDieov[gi]), .pullupEn(pullupD[gi]),
            .driveEn(driveEnD[gi]), .driveVal(driveValD[gi]),
            .inputEn(inputEnD[gi]), .digitalIn(digD[gi]));
      end
   endgenerate

   // *************************
   // inputs routed to peripherals
   // *************************
   always_comb begin
      route_next = route_reg;
      route_next.pinChangeSource     = digB;
      route_next.serialUnitClockPin  = digB[`PBD_PB_SCLK];
      // slave-in / master-in half of the serial pair
      route_next.serialDataIn        = digB[`PBD_PB_SDA];
      route_next.captureTriggerIn    = digD[`PBD_PD_CAPT] & captureEn;
      route_next.timer1ExtCountClock = digD[`PBD_PD_T1CK] & t1ClkEn;
      route_next.timer0ExtCountClock = digD[`PBD_PD_T0CK] & t0ClkEn;
      route_next.extIrqOneInput      = digD[`PBD_PD_IRQ1];
      route_next.extIrqZeroInput     = digD[`PBD_PD_IRQ0];
      route_next.usartSyncClockIn    = digD[`PBD_PD_IRQ0] & xckInEn;
      route_next.rxDataIn            = digD[`PBD_PD_RXD] & rxEnable;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         route_reg <= '0;
      end else begin
         route_reg <= route_next;
      end
   end

   // field order matches the route struct
   assign {pinChangeSource, serialUnitClockPin, serialDataIn, captureTriggerIn,
           timer1ExtCountClock, timer0ExtCountClock, extIrqOneInput, extIrqZeroInput,
           usartSyncClockIn, rxDataIn} = route_reg;

   // *************************
   // checks
   // *************************
   property p_t1a;
      @(posedge clock) disable iff (!resetn)
      timer1CompareAEn && directionB[3]
      |=> driveEnB[3] && driveValB[3] == $past(timer1CompareAOut);
   endproperty
   a_t1a: assert property (p_t1a)
      else $error("timer1 compare-A not on port b bit 3");
   property p_t0a;
      @(posedge clock) disable iff (!resetn)
      timer0CompareAEn
      |=> driveValB[2] == $past(timer0CompareAOut) && driveEnB[2] == $past(directionB[2]);
   endproperty
   a_t0a: assert property (p_t0a)
      else $error("timer0 compare-A not on port b bit 2");
   property p_pin_change_source;
      @(posedge clock) disable iff (!resetn)
      pinChangeIrqEn && pinChangeMask[0]
      |=> inputEnB[0] ##1 pinChangeSource[0] == $past(padInB[0], 2);
   endproperty
   a_pin_change_source: assert property (p_pin_change_source)
      else $error("pin-change input not forced on");
   property p_threewire;
      @(posedge clock) disable iff (!resetn)
      serialUnit3wireMode |=> driveValB[6] == $past(serialDataOut);
   endproperty
   a_threewire: assert property (p_threewire)
      else $error("data out not on port b bit 6");
   property p_capture;
      @(posedge clock) disable iff (!resetn)
      captureEn |=> inputEnD[6];
   endproperty
   a_capture: assert property (p_capture)
      else $error("capture input not forced on");
   property p_t0b;
      @(posedge clock) disable iff (!resetn)
      timer0CompareBEn |=> driveValD[5] == $past(timer0CompareBOut);
   endproperty
   a_t0b: assert property (p_t0b)
      else $error("timer0 compare-B not on port d bit 5");
   property p_t0clk;
      @(posedge clock) disable iff (!resetn)
      !(&timer0ClockSelect21) |=> !timer0ExtCountClock;
   endproperty
   a_t0clk: assert property (p_t0clk)
      else $error("timer0 external clock leaks while not selected");
   property p_tx;
      @(posedge clock) disable iff (!resetn)
      txEnable |=> driveEnD[1] && !pullupD[1] && !inputEnD[1] && driveValD[1] == $past(txData);
   endproperty
   a_tx: assert property (p_tx)
      else $error("transmitter pin not taken over");
   property p_rx;
      @(posedge clock) disable iff (!resetn)
      rxEnable |=> !driveEnD[0] && pullupD[0] == ($past(portD[0]) && !$past(globalPullupDisable));
   endproperty
   a_rx: assert property (p_rx)
      else $error("receiver pin not forced to input");
   property p_twolow;
      @(posedge clock) disable iff (!resetn)
      serialUnit2wireMode && directionB[5] |=> !driveValB[5];
   endproperty
   a_twolow: assert property (p_twolow)
      else $error("two-wire data pin driven high");
   property p_sysclk_output;
      @(posedge clock) disable iff (!resetn)
      sysclkOutputSel |=> driveValD[2] == $past(sysclkLevel);
   endproperty
   a_sysclk_output: assert property (p_sysclk_output)
      else $error("clock output not on port d bit 2");

   c_tx: cover property (@(posedge clock) disable iff (!resetn) txEnable ##1 driveEnD[1]);
   c_twowire: cover property (@(posedge clock) disable iff (!resetn)
      serialUnit2wireMode && serialUnitClockStretch ##1 driveEnB[7]);
   c_xck: cover property (@(posedge clock) disable iff (!resetn) usartSyncClockIn);
   c_pin_change_source: cover property (@(posedge clock) disable iff (!resetn) sleepMode && inputEnB[3]);
endmodule : pbd_alt_override

// File: design/pbd_pin_cell.sv
// generic override cell for one port pin, outputs registered
// assumes synchronous pad input and override terms from the parent
module pbd_pin_cell (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic direction,
   input  wire logic portBit,
   input  wire logic globalPullupDisable,
   input  wire logic sleepMode,
   input  wire logic padIn,
   input  wire logic pullupOverrideEn,
   input  wire logic pullupOverrideVal,
   input  wire logic directionOverrideEn,
   input  wire logic directionOverrideVal,
   input  wire logic valueOverrideEn,
   input  wire logic valueOverrideVal,
   input  wire logic toggleOverrideEn,
   input  wire logic inputEnableOverrideEn,
   input  wire logic inputEnableOverrideVal,
   output logic      pullupEn,
   output logic      driveEn,
   output logic      driveVal,
   output logic      inputEn,
   output logic      digitalIn
);
   import pbd_pkg::*;
   pbd_cell_s state_reg;
   pbd_cell_s state_next;

   // *************************
   // override resolution
   // *************************
   always_comb begin
      state_next = state_reg;
      // pull-up only when input, port bit one and pull-ups allowed
      state_next.pullupEn = pullupOverrideEn ? pullupOverrideVal
                          : (~direction & portBit & ~globalPullupDisable);
      state_next.driveEn = directionOverrideEn ? directionOverrideVal : direction;
      // toggle inverts the port bit, value override replaces it
      state_next.driveVal = valueOverrideEn ? valueOverrideVal
                          : (portBit ^ toggleOverrideEn);
      // input buffer follows sleep state unless a function forces it
      state_next.inputEn = inputEnableOverrideEn ? inputEnableOverrideVal : ~sleepMode;
      state_next.digitalIn = padIn & state_next.inputEn;
   end

   // *************************
   // state register
   // *************************
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign pullupEn  = state_reg.pullupEn;
   assign driveEn   = state_reg.driveEn;
   assign driveVal  = state_reg.driveVal;
   assign inputEn   = state_reg.inputEn;
   assign digitalIn = state_reg.digitalIn;

   property p_pullup_override;
      @(posedge clock) disable iff (!resetn)
      pullupOverrideEn |=> pullupEn == $past(pullupOverrideVal);
   endproperty
   a_pullup_override: assert property (p_pullup_override)
      else $error("pull-up ignores its override");

   property p_value_override;
      @(posedge clock) disable iff (!resetn)
      valueOverrideEn |=> driveVal == $past(valueOverrideVal);
   endproperty
   a_value_override: assert property (p_value_override)
      else $error("drive value ignores its override");
endmodule : pbd_pin_cell

// File: pkg/pbd_params.svh
// pin positions and widths for the port b / port d override block
// assumes inclusion by pbd_pkg and the design files only
`ifndef PBD_PARAMS_SVH
`define PBD_PARAMS_SVH
`define PBD_PORTB_W 8
`define PBD_PORTD_W 7
`define PBD_PB_SCLK 7
`define PBD_PB_SDO 6
`define PBD_PB_SDA 5
`define PBD_PB_T1CB 4
`define PBD_PB_T1CA 3
`define PBD_PB_T0CA 2
`define PBD_PD_CAPT 6
`define PBD_PD_T1CK 5
`define PBD_PD_T0CK 4
`define PBD_PD_IRQ1 3
`define PBD_PD_IRQ0 2
`define PBD_PD_TXD 1
`define PBD_PD_RXD 0
`define PBD_RST_BIT 1'b0
`endif

// File: pkg/pbd_pkg.sv
// types shared by the pin cell and the override block
// assumes pbd_params.svh sits beside it on the include path
`include "pbd_params.svh"
package pbd_pkg;
   // registered pad controls of one pin
   typedef struct packed {
      logic pullupEn;
      logic driveEn;
      logic driveVal;
      logic inputEn;
      logic digitalIn;
   } pbd_cell_s;
   // registered inputs routed to the peripherals
   typedef struct packed {
      logic [`PBD_PORTB_W-1:0] pinChangeSource;
      logic                    serialUnitClockPin;
      logic                    serialDataIn;
      logic                    captureTriggerIn;
      logic                    timer1ExtCountClock;
      logic                    timer0ExtCountClock;
      logic                    extIrqOneInput;
      logic                    extIrqZeroInput;
      logic                    usartSyncClockIn;
      logic                    rxDataIn;
   } pbd_route_s;
endpackage : pbd_pkg

// File: testbench/pbd_pad_model.sv
// pad model: resolves each pin from device drive, outside drive and pull-up
// assumes one clock; an undriven pin without pull-up toggles every cycle
module pbd_pad_model #(
   parameter int W = 8
) (
   input  wire logic         clock,
   input  wire logic [W-1:0] driveEn,
   input  wire logic [W-1:0] driveVal,
   input  wire logic [W-1:0] pullupOn,
   input  wire logic [W-1:0] extDrive,
   input  wire logic [W-1:0] extLevel,
   output logic [W-1:0]      padIn
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [W-1:0] floatPat = '0;
   // floating pins change each cycle so a stale level never passes for a match
   always @(posedge clock) floatPat <= ~floatPat;
   // device driver wins, then outside driver, then pull-up
   assign padIn = (driveEn & driveVal) | (~driveEn & extDrive & extLevel)
                | (~driveEn & ~extDrive & (pullupOn | floatPat));
endmodule : pbd_pad_model

// File: testbench/tb_pbd_alt_override.sv
// self-checking bench for the port b / port d override block
// assumes pad model beside the block; inputs change on the falling edge
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module tb_pbd_alt_override;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock = 0, resetn = 0;
   logic globalPullupDisable, sleepMode, pinChangeIrqEn, serialUnit2wireMode;
   logic serialUnit3wireMode, serialUnitClockStretch, serialUnitStartIrqEn;
   logic serialUnitClockToggle, serialDataOut, timer1CompareAEn, timer1CompareAOut;
   logic timer1CompareBEn, timer1CompareBOut, timer0CompareAEn, timer0CompareAOut;
   logic timer0CompareBEn, timer0CompareBOut, captureEn, extIrqOneEn, extIrqZeroEn;
   logic usartSyncMode, usartSyncClockOutEn, usartSyncClockOut, sysclkOutputSel;
   logic sysclkLevel, txEnable, txData, rxEnable;
   logic [7:0] portB, directionB, padInB, pinChangeMask, extB, extDriveB;
   logic [7:0] pullupB, driveEnB, driveValB, inputEnB, pinChangeSource;
   logic [6:0] portD, directionD, padInD, extD, extDriveD;
   logic [6:0] pullupD, driveEnD, driveValD, inputEnD;
   logic [1:0] timer1ClockSelect21, timer0ClockSelect21;
   logic serialUnitClockPin, serialDataIn, captureTriggerIn, timer1ExtCountClock;
   logic timer0ExtCountClock, extIrqOneInput, extIrqZeroInput, usartSyncClockIn, rxDataIn;
   int err_total = 0;
   int n_checks = 0;

   pbd_alt_override dut (.clock, .resetn, .globalPullupDisable, .sleepMode, .portB,
      .directionB, .padInB, .portD, .directionD, .padInD, .pinChangeMask, .pinChangeIrqEn,
      .serialUnit2wireMode, .serialUnit3wireMode, .serialUnitClockStretch,
      .serialUnitStartIrqEn, .serialUnitClockToggle, .serialDataOut, .timer1CompareAEn,
      .timer1CompareAOut, .timer1CompareBEn, .timer1CompareBOut, .timer0CompareAEn,
      .timer0CompareAOut, .timer0CompareBEn, .timer0CompareBOut, .captureEn,
      .timer1ClockSelect21, .timer0ClockSelect21, .extIrqOneEn, .extIrqZeroEn,
      .usartSyncMode, .usartSyncClockOutEn, .usartSyncClockOut, .sysclkOutputSel,
      .sysclkLevel, .txEnable, .txData, .rxEnable, .pullupB, .driveEnB, .driveValB,
      .inputEnB, .pullupD, .driveEnD, .driveValD, .inputEnD, .pinChangeSource,
      .serialUnitClockPin, .serialDataIn, .captureTriggerIn, .timer1ExtCountClock,
      .timer0ExtCountClock, .extIrqOneInput, .extIrqZeroInput, .usartSyncClockIn, .rxDataIn);
   pbd_pad_model #(.W(8)) padsB (.clock, .driveEn(driveEnB), .driveVal(driveValB),
      .pullupOn(pullupB), .extDrive(extDriveB), .extLevel(extB), .padIn(padInB));
   pbd_pad_model #(.W(7)) padsD (.clock, .driveEn(driveEnD), .driveVal(driveValD),
      .pullupOn(pullupD), .extDrive(extDriveD), .extLevel(extD), .padIn(padInD));

   always #50 clock = ~clock;

   // let n falling edges pass; outputs are settled there
   task automatic step(input int n);
      repeat (n) @(negedge clock);
   endtask : step

   task automatic summarize;
      $display("checks=%0d mismatches=%0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : summarize

   // watchdog: tests take well under a hundred cycles
   initial begin
      #100000;
      err_total++;
      summarize();
   end

   // *****************************************************
   // test sequence
   // *****************************************************
   initial begin
      {globalPullupDisable, sleepMode, pinChangeIrqEn, serialUnit2wireMode,
       serialUnit3wireMode, serialUnitClockStretch, serialUnitStartIrqEn,
       serialUnitClockToggle, serialDataOut, timer1CompareAEn, timer1CompareAOut,
       timer1CompareBEn, timer1CompareBOut, timer0CompareAEn, timer0CompareAOut,
       timer0CompareBEn, timer0CompareBOut, captureEn, extIrqOneEn, extIrqZeroEn,
       usartSyncMode, usartSyncClockOutEn, usartSyncClockOut, sysclkOutputSel,
       sysclkLevel, txEnable, txData, rxEnable} = '0;
      {portB, directionB, pinChangeMask, extB, extDriveB} = '0;
      {portD, directionD, extD, extDriveD, timer1ClockSelect21, timer0ClockSelect21} = '0;
      step(20);
      `CHK(driveEnB, 8'h00)
      resetn = 1;
      // plain port: analog pins 1:0 kept input with pull-up off
      directionB = 8'h3c;
      portB = 8'ha4;
      step(3);
      `CHK(pullupB, 8'h80)
      `CHK(driveEnB, 8'h3c)
      `CHK(driveValB, 8'ha4)
      `CHK(serialDataIn, 1'b1)
      globalPullupDisable = 1;
      step(2);
      `CHK(pullupB, 8'h00)
      globalPullupDisable = 0;
      {timer1CompareAEn, timer1CompareAOut, timer0CompareAEn} = 3'b111;
      {timer1CompareBEn, timer1CompareBOut} = 2'b11;
      step(2);
      `CHK(driveValB, 8'hb8)
      directionB = 8'h30;
      step(2);
      `CHK(driveEnB, 8'h30)
      {timer1CompareAEn, timer0CompareAEn, timer1CompareBEn} = '0;
      // serial unit three-wire then two-wire
      {portB, directionB, serialUnit3wireMode, serialDataOut} = {8'h00, 8'h40, 2'b11};
      step(2);
      `CHK(driveValB, 8'h40)
      {serialUnit3wireMode, serialUnit2wireMode, directionB, portB} = {2'b01, 8'ha0, 8'h80};
      step(2);
      `CHK(driveEnB, 8'h20)
      serialUnitClockStretch = 1;
      step(2);
      `CHK(driveEnB, 8'ha0)
      `CHK(driveValB, 8'h00)
      {serialUnit2wireMode, serialUnitClockStretch, directionB, portB} = '0;
      // sleep: only pin-change and start-detect pins keep their inputs
      {sleepMode, pinChangeIrqEn, serialUnitStartIrqEn, pinChangeMask} = {3'b111, 8'h11};
      {extDriveB, extB} = 16'hffff;
      step(3);
      `CHK(inputEnB, 8'hb1)
      `CHK(pinChangeSource, 8'hb1)
      `CHK(serialUnitClockPin, 1'b1)
      pinChangeIrqEn = 0;
      step(2);
      `CHK(inputEnB, 8'ha0)
      {sleepMode, serialUnitStartIrqEn, extDriveB} = '0;
      // transmitter and receiver take pins 1 and 0
      {portD, directionD, txEnable, txData, rxEnable} = {7'h01, 7'h01, 3'b111};
      {extDriveD, extD} = 14'h3fff;
      step(3);
      `CHK(driveEnD, 7'h02)
      `CHK(driveValD, 7'h03)
      `CHK(pullupD, 7'h01)
      `CHK(inputEnD, 7'h7d)
      `CHK(rxDataIn, 1'b1)
      // sleep with capture, timer1 clock and irq one enabled; timer0 clock left off
      {txEnable, rxEnable, directionD, portD, sleepMode, captureEn} = {16'h0000, 2'b11};
      {timer1ClockSelect21, timer0ClockSelect21, extIrqOneEn} = 5'b11101;
      step(3);
      `CHK(inputEnD, 7'h68)
      `CHK(captureTriggerIn, 1'b1)
      `CHK(timer1ExtCountClock, 1'b1)
      `CHK(timer0ExtCountClock, 1'b0)
      `CHK(extIrqOneInput, 1'b1)
      `CHK(extIrqZeroInput, 1'b0)
      // pin 2 clock sources and compare-B on pin 5
      {sleepMode, captureEn, timer1ClockSelect21, extIrqOneEn, extDriveD} = '0;
      {directionD, portD, timer0CompareBEn, timer0CompareBOut} = {7'h24, 7'h04, 2'b11};
      {sysclkOutputSel, sysclkLevel, usartSyncMode, usartSyncClockOutEn} = 4'hf;
      step(3);
      `CHK(driveValD, 7'h24)
      sysclkOutputSel = 0;
      step(3);
      `CHK(driveValD, 7'h20)
      usartSyncMode = 0;
      step(3);
      `CHK(driveValD, 7'h24)
      // usart clock in, timer0 clock and clock-pin toggle, pins asleep
      {usartSyncClockOutEn, sleepMode, directionD, serialUnitClockToggle} = {2'b01, 7'h00, 1'b1};
      {usartSyncMode, timer0ClockSelect21, extDriveD} = {3'b111, 7'h14};
      step(3);
      `CHK(inputEnD, 7'h14)
      `CHK(usartSyncClockIn, 1'b1)
      `CHK(extIrqZeroInput, 1'b1)
      `CHK(timer0ExtCountClock, 1'b1)
      `CHK(driveValB, 8'h80)
      summarize();
   end
endmodule : tb_pbd_alt_override
